// ==== hdl/cfps_ctrl.v ====
/*
 * clock fail monitor and power save controller: fail-safe switch to the
 * fast rc oscillator, sleep and idle entry and wake, doze divider for the
 * cpu clock enable and per-peripheral clock gating, with an apb slave.
 * assumes the cpu pulses the power save instruction input, and that
 * interrupt, watchdog time-out and oscillator fail inputs are synchronous.
 */
// Added by the designer: the register offsets and the APB register port.
// Function
// - monitor enabled keeps low power rc running except in sleep, watchdog cannot stop.
// - active oscillator failure raises trap and switches system clock to fast rc.
// - pll factor in use at failure stays applied to the fast rc clock.
// - sleep or idle entered only by power save instruction; operand picks mode.
// - sleep shuts down the system clock source and its oscillator.
// - clock fail monitor is inactive during sleep.
// - low power rc keeps running in sleep when watchdog enabled.
// - watchdog cleared automatically on entering sleep and on entering idle. here only while the watchdog enable bit is set.
// - sleep disables system clocked peripherals; externally clocked ones keep going.
// - wake from sleep or idle on enabled interrupt, reset or watchdog time-out.
// - wake from sleep resumes with the same system clock source.
// - idle stops cpu execution, system clock and peripherals keep running.
// - in idle low power rc runs if watchdog or monitor enabled.
// - idle wake reapplies cpu clock, execution resumes 2 to 4 cycles later.
// - interrupt during power save instruction deferred until entry completes, then wakes.
// - doze slows only cpu clock; system and peripheral clocks unchanged, synchronous.
// - doze enable bit 11 of clock divisor activates reduced cpu clock.
// - ratio field bits 14:12 picks 1:1 to 1:128, default 1:1.
// - return on interrupt bit 15 set restores full speed on interrupt.
// - disable bit stops module clocks; its register access is blocked. here only the module clock enable is gated.
// - module enabled only if present and disable bit clear; default clear.
// - disable bit change takes effect one instruction cycle after write.
// - clock switch config bit at one disables switching and monitor, default.
`timescale 1ns/10ps
`include "cfps_regs.vh"

module cfps_ctrl (
    input wire i_sys_clk,
    input wire i_rstn,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [`CFPS_ADDR_W-1:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output wire [31:0] o_prdata,
    output wire o_pslverr,
    // cpu side
    input wire i_power_save_instr_exec,
    input wire i_power_save_instr_mode,
    input wire i_irq_pending,
    input wire i_wdt_timeout,
    input wire i_osc_fail,
    output wire o_cpu_clk_en,
    output wire o_wdt_clear,
    output wire o_clk_fail_trap,
    // clock sources
    output wire o_sys_osc_en,
    output wire [2:0] o_sys_clk_sel,
    output wire o_pll_en,
    output wire o_low_power_rc_osc_en,
    output wire o_fail_safe_clock_monitor_active,
    // peripheral clock gates
    output wire [`CFPS_NPER-1:0] o_periph_clk_en
);

// power save sequencer states, binary coded
localparam ST_RUN = 3'h0;
localparam ST_ENTER = 3'h1;
localparam ST_SLEEP = 3'h2;
localparam ST_IDLE = 3'h3;
localparam ST_WAKE = 3'h4;

////////////////////////////////////////////////////////////////////////
// registers

// apb answer
reg pready_ff;
reg [31:0] prdata_ff;
reg pslverr_ff;
// software visible control bits
reg roi_ff;
reg [2:0] ratio_ff;
reg doze_enable_ff;
reg [`CFPS_NPER-1:0] peripheral_disable_bits_ff;
reg clock_switch_cfg_bit_ff;
reg wdt_en_ff;
reg pll_ff;
reg [2:0] next_osc_select_ff;
reg [2:0] cur_osc_ff;
reg fail_ff;
// sequencer, divider and registered outputs
reg [2:0] state_ff;
reg [2:0] nxt_state;
reg sel_mode_ff;
reg [1:0] wake_cnt_ff;
reg [6:0] doze_cnt_ff;
reg cpu_clk_en_ff;
reg wdt_clear_ff;
reg trap_ff;
reg sys_osc_en_ff;
reg low_power_rc_osc_en_ff;
reg fail_safe_clock_monitor_active_ff;
reg [`CFPS_NPER-1:0] periph_clk_en_ff;

// decode and next-value helpers
wire fail_safe_clock_monitor_en;
wire apb_wr;
wire apb_rd;
wire hit_div;
wire hit_pmd;
wire hit_cfg;
wire hit_stat;
wire hit_any;
wire fail_evt;
wire wake_evt;
wire [6:0] doze_top;
wire doze_tick;
wire [`CFPS_NPER-1:0] enabled_per;
wire [`CFPS_NPER-1:0] nxt_periph;
wire [`CFPS_NPER-1:0] ext_per;

// monitor and switching run only with the config bit programmed low
assign fail_safe_clock_monitor_en = ~clock_switch_cfg_bit_ff;
// failures count only while the monitor shows active, so the trap and
// the active flag never disagree for a cycle after a config write
assign fail_evt = fail_safe_clock_monitor_active_ff & i_osc_fail;
assign wake_evt = i_irq_pending | i_wdt_timeout;

////////////////////////////////////////////////////////////////////////
// apb slave: one wait cycle, answer registered

assign apb_wr = i_psel & i_penable & pready_ff & i_pwrite;
assign apb_rd = i_psel & ~i_penable & ~i_pwrite;
assign hit_div = (i_paddr == `CFPS_OFS_CLOCK_DIVISOR_REG);
assign hit_pmd = (i_paddr == `CFPS_OFS_PMD);
assign hit_cfg = (i_paddr == `CFPS_OFS_CFG);
assign hit_stat = (i_paddr == `CFPS_OFS_STAT);
assign hit_any = hit_div | hit_pmd | hit_cfg | hit_stat;

// pready rises in the second access cycle, then drops
always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
    end else begin
        pready_ff <= i_psel & i_penable & ~pready_ff;
        pslverr_ff <= i_psel & i_penable & ~pready_ff & ~hit_any;
    end
end

// read data captured in setup, stable through the access phase
always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        prdata_ff <= 32'h0;
    end else if (apb_rd) begin
        if (hit_div) begin
            prdata_ff <= {16'h0, roi_ff, ratio_ff, doze_enable_ff, 11'h0};
        end else if (hit_pmd) begin
            prdata_ff <= {16'h0, peripheral_disable_bits_ff};
        end else if (hit_cfg) begin
            prdata_ff <= {25'h0, next_osc_select_ff, 1'b0, pll_ff,
                          wdt_en_ff, clock_switch_cfg_bit_ff};
        end else if (hit_stat) begin
            prdata_ff <= {21'h0, state_ff, 1'b0, cur_osc_ff, 2'h0,
                          fail_safe_clock_monitor_active_ff, fail_ff};
        end else begin
            // unmapped offsets read as zero, pslverr flags them
            prdata_ff <= 32'h0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// clock divisor register; hardware clear of doze on interrupt loses
// against a software write in the same cycle

always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        roi_ff <= 1'b0;
        ratio_ff <= `CFPS_RATIO_RST;
        doze_enable_ff <= 1'b0;
    end else if (apb_wr && hit_div) begin
        roi_ff <= i_pwdata[`CFPS_DIV_ROI];
        ratio_ff <= i_pwdata[`CFPS_DIV_RATIO_HI:`CFPS_DIV_RATIO_LO];
        doze_enable_ff <= i_pwdata[`CFPS_DIV_DOZE_ENABLE];
    end else if (roi_ff && i_irq_pending) begin
        doze_enable_ff <= 1'b0;
    end
end

// peripheral disable bits, reset clear
always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        peripheral_disable_bits_ff <= {`CFPS_NPER{1'b0}};
    end else if (apb_wr && hit_pmd) begin
        peripheral_disable_bits_ff <= i_pwdata[`CFPS_NPER-1:0];
    end
end

// configuration: switch disable bit, watchdog enable, pll, next source
always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        clock_switch_cfg_bit_ff <= `CFPS_CKSW_RST;
        wdt_en_ff <= 1'b0;
        pll_ff <= 1'b0;
        next_osc_select_ff <= `CFPS_OSC_RST;
    end else if (apb_wr && hit_cfg) begin
        clock_switch_cfg_bit_ff <= i_pwdata[`CFPS_CFG_CKSW];
        wdt_en_ff <= i_pwdata[`CFPS_CFG_WDTEN];
        pll_ff <= i_pwdata[`CFPS_CFG_PLL];
        next_osc_select_ff <= i_pwdata[`CFPS_CFG_NOSC_HI:`CFPS_CFG_NOSC_LO];
    end
end

////////////////////////////////////////////////////////////////////////
// active source; failure forces fast rc and keeps the pll factor

always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        cur_osc_ff <= `CFPS_OSC_RST;
        fail_ff <= 1'b0;
        trap_ff <= 1'b0;
    end else begin
        trap_ff <= fail_evt;
        if (fail_evt) begin
            cur_osc_ff <= `CFPS_OSC_FRC;
        end else if (fail_safe_clock_monitor_en && !fail_ff && (state_ff == ST_RUN)) begin
            // switching only when enabled; sleep leaves it untouched.
            // after a failure the fast rc stays in use until software
            // clears the fail flag, else the dead source would come
            // straight back on the next cycle
            cur_osc_ff <= next_osc_select_ff;
        end
        // sticky fail flag, set wins over a write-one clear
        if (fail_evt) begin
            fail_ff <= 1'b1;
        end else if (apb_wr && hit_stat && i_pwdata[`CFPS_ST_FAIL]) begin
            fail_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// power save sequencer

always @* begin
    nxt_state = state_ff;
    case (state_ff)
        ST_RUN: begin
            if (i_power_save_instr_exec) begin
                nxt_state = ST_ENTER;
            end
        end
        ST_ENTER: begin
            // interrupts here wait until the mode is reached
            if (sel_mode_ff == `CFPS_PSEL_SLEEP) begin
                nxt_state = ST_SLEEP;
            end else begin
                nxt_state = ST_IDLE;
            end
        end
        ST_SLEEP: begin
            if (wake_evt) begin
                nxt_state = ST_WAKE;
            end
        end
        ST_IDLE: begin
            if (wake_evt) begin
                nxt_state = ST_WAKE;
            end
        end
        ST_WAKE: begin
            if (wake_cnt_ff == `CFPS_WAKE_CYC) begin
                nxt_state = ST_RUN;
            end
        end
        default: begin
            nxt_state = ST_RUN;
        end
    endcase
end

always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        state_ff <= ST_RUN;
        sel_mode_ff <= 1'b0;
        wake_cnt_ff <= 2'h0;
        wdt_clear_ff <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        if (state_ff == ST_RUN && i_power_save_instr_exec) begin
            sel_mode_ff <= i_power_save_instr_mode;
        end
        // counts the cycles spent waking; cleared in every other state
        if (state_ff == ST_WAKE) begin
            wake_cnt_ff <= wake_cnt_ff + 2'h1;
        end else begin
            wake_cnt_ff <= 2'h0;
        end
        // one pulse on entry to either mode, only while the watchdog is enabled
        wdt_clear_ff <= (state_ff == ST_ENTER) & wdt_en_ff;
    end
end

////////////////////////////////////////////////////////////////////////
// doze divider: free counter gives one enable per selected ratio

// last count of each period: ratio n gives 2^n cycles, so 0 ticks
// every cycle and the widest ratio lands on the full counter
assign doze_top = 7'h7f >> (3'h7 - ratio_ff);
assign doze_tick = ~doze_enable_ff | (doze_cnt_ff == doze_top);

always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        doze_cnt_ff <= 7'h0;
    end else if (doze_tick) begin
        doze_cnt_ff <= 7'h0;
    end else begin
        doze_cnt_ff <= doze_cnt_ff + 7'h1;
    end
end

////////////////////////////////////////////////////////////////////////
// clock enables; all registered so the gates see no glitches

assign enabled_per = `CFPS_PER_PRESENT & ~peripheral_disable_bits_ff;
// the external clock mask as a net, so each bit is a plain one-bit select
assign ext_per = `CFPS_PER_EXTCLK;

genvar gi;
generate
    for (gi = 0; gi < `CFPS_NPER; gi = gi + 1) begin : g_per
        // in sleep only externally clocked modules survive
        assign nxt_periph[gi] = enabled_per[gi] &
            ((nxt_state != ST_SLEEP) | ext_per[gi]);
    end
endgenerate

always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        cpu_clk_en_ff <= 1'b1;
        sys_osc_en_ff <= 1'b1;
        low_power_rc_osc_en_ff <= 1'b0;
        fail_safe_clock_monitor_active_ff <= 1'b0;
        periph_clk_en_ff <= `CFPS_PER_PRESENT;
    end else begin
        // cpu stops in all modes, dozes in run
        cpu_clk_en_ff <= (nxt_state == ST_RUN) & doze_tick;
        sys_osc_en_ff <= (nxt_state != ST_SLEEP);
        low_power_rc_osc_en_ff <= wdt_en_ff |
                      (fail_safe_clock_monitor_en & (nxt_state != ST_SLEEP));
        fail_safe_clock_monitor_active_ff <= fail_safe_clock_monitor_en & (nxt_state != ST_SLEEP);
        periph_clk_en_ff <= nxt_periph;
    end
end

////////////////////////////////////////////////////////////////////////
// outputs, each straight from its flip-flop so nothing downstream
// sees a decode glitch

assign o_pready = pready_ff;
assign o_prdata = prdata_ff;
assign o_pslverr = pslverr_ff;
assign o_cpu_clk_en = cpu_clk_en_ff;
assign o_wdt_clear = wdt_clear_ff;
assign o_clk_fail_trap = trap_ff;
assign o_sys_osc_en = sys_osc_en_ff;
assign o_sys_clk_sel = cur_osc_ff;
assign o_pll_en = pll_ff;
assign o_low_power_rc_osc_en = low_power_rc_osc_en_ff;
assign o_fail_safe_clock_monitor_active = fail_safe_clock_monitor_active_ff;
assign o_periph_clk_en = periph_clk_en_ff;

endmodule

// ==== hdl/cfps_regs.vh ====
/*
 * register offsets, field positions, reset values and codes for the
 * clock fail and power save controller.
 * assumes an apb slave with 32-bit data, one register per aligned word.
 */
`ifndef CFPS_REGS_VH
`define CFPS_REGS_VH

// apb byte addresses
`define CFPS_ADDR_W 12
`define CFPS_OFS_CLOCK_DIVISOR_REG 12'h000
`define CFPS_OFS_PMD 12'h004
`define CFPS_OFS_CFG 12'h008
`define CFPS_OFS_STAT 12'h00c

// clock divisor register fields
`define CFPS_DIV_ROI 15
`define CFPS_DIV_RATIO_HI 14
`define CFPS_DIV_RATIO_LO 12
`define CFPS_DIV_DOZE_ENABLE 11
`define CFPS_RATIO_RST 3'h0

// configuration register fields
`define CFPS_CFG_CKSW 0
`define CFPS_CFG_WDTEN 1
`define CFPS_CFG_PLL 2
`define CFPS_CFG_NOSC_HI 6
`define CFPS_CFG_NOSC_LO 4
`define CFPS_CKSW_RST 1'h1

// status register fields
`define CFPS_ST_FAIL 0
`define CFPS_ST_FAIL_SAFE_CLOCK_MONITOR 1
`define CFPS_ST_COSC_HI 6
`define CFPS_ST_COSC_LO 4
`define CFPS_ST_STATE_HI 10
`define CFPS_ST_STATE_LO 8

// oscillator codes
`define CFPS_OSC_FRC 3'h0
`define CFPS_OSC_RST 3'h0

// peripheral disable bits
`define CFPS_NPER 16
`define CFPS_PER_PRESENT 16'h1fab
`define CFPS_PER_EXTCLK 16'h0003

// wake delay before the cpu clock returns, within 2 to 4 cycles
`define CFPS_WAKE_CYC 2'h2
`define CFPS_PSEL_SLEEP 1'h0

`endif

// ==== tb/cfps_ctrl_properties.sv ====
/* assertions on the cfps_ctrl ports.
   assumes power save is only issued while the cpu clock runs. */
`timescale 1ns/10ps
`include "cfps_regs.vh"
module cfps_ctrl_properties (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [`CFPS_ADDR_W-1:0] i_paddr,
    input wire i_power_save_instr_exec,
    input wire i_power_save_instr_mode,
    input wire i_osc_fail,
    input wire o_pready,
    input wire o_cpu_clk_en,
    input wire o_wdt_clear,
    input wire o_clk_fail_trap,
    input wire o_sys_osc_en,
    input wire [2:0] o_sys_clk_sel,
    input wire o_pll_en,
    input wire o_low_power_rc_osc_en,
    input wire o_fail_safe_clock_monitor_active,
    input wire [`CFPS_NPER-1:0] o_periph_clk_en
);
// a peripheral disable write completes in this cycle
wire pmd_wr = i_psel && i_penable && i_pwrite && o_pready &&
    i_paddr == `CFPS_OFS_PMD;
default clocking @(posedge i_sys_clk); endclocking
default disable iff (!i_rstn);
////////////////////////////////////////
low_power_rc_osc_fail_safe_clock_monitor_a: assert property (
    o_fail_safe_clock_monitor_active |-> o_low_power_rc_osc_en) else $error("low_power_rc_osc stopped");
fail_trap_a: assert property (
    i_osc_fail && o_fail_safe_clock_monitor_active |=> o_clk_fail_trap &&
    o_sys_clk_sel == 3'h0) else $error("no trap or no fallback");
fail_pll_a: assert property (
    o_clk_fail_trap |-> o_pll_en == $past(o_pll_en))
    else $error("pll factor lost on failure");
sleep_entry_a: assert property (
    $fell(o_sys_osc_en) |-> $past(i_power_save_instr_exec, 2) &&
    !$past(i_power_save_instr_mode, 2)) else $error("osc stopped without sleep");
sleep_fail_safe_clock_monitor_a: assert property (
    !o_sys_osc_en |-> !o_fail_safe_clock_monitor_active) else $error("monitor on in sleep");
wdt_clear_a: assert property (
    o_wdt_clear |-> !o_cpu_clk_en && $past(i_power_save_instr_exec, 2))
    else $error("stray watchdog clear");
sleep_gate_a: assert property (
    !o_sys_osc_en |-> (o_periph_clk_en & ~`CFPS_PER_EXTCLK) == 16'h0)
    else $error("peripheral clocked in sleep");
idle_osc_a: assert property (
    i_power_save_instr_exec && i_power_save_instr_mode && o_cpu_clk_en |=> o_sys_osc_en [*3])
    else $error("system clock lost in idle");
absent_off_a: assert property (
    (o_periph_clk_en & ~`CFPS_PER_PRESENT) == 16'h0)
    else $error("absent peripheral clocked");
gate_delay_a: assert property (
    $changed(o_periph_clk_en) && o_sys_osc_en && $past(o_sys_osc_en) &&
    $past(o_sys_osc_en, 2) |-> $past(pmd_wr, 2))
    else $error("gate change off its write slot");
endmodule
////////////////////////////////////////
bind cfps_ctrl cfps_ctrl_properties u_props (.i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_power_save_instr_exec(i_power_save_instr_exec),
    .i_power_save_instr_mode(i_power_save_instr_mode), .i_osc_fail(i_osc_fail),
    .o_pready(o_pready), .o_cpu_clk_en(o_cpu_clk_en),
    .o_wdt_clear(o_wdt_clear), .o_clk_fail_trap(o_clk_fail_trap),
    .o_sys_osc_en(o_sys_osc_en), .o_sys_clk_sel(o_sys_clk_sel),
    .o_pll_en(o_pll_en), .o_low_power_rc_osc_en(o_low_power_rc_osc_en),
    .o_fail_safe_clock_monitor_active(o_fail_safe_clock_monitor_active), .o_periph_clk_en(o_periph_clk_en));

// ==== tb/cfps_cpu_model.sv ====
/* cpu and interrupt source model facing cfps_ctrl.
   assumes the bench asks for one instruction at a time. */
`timescale 1ns/10ps
module cfps_cpu_model (
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_cpu_clk_en,
    input wire i_go,
    input wire i_mode,
    input wire i_irq_req,
    output reg o_exec,
    output reg o_mode,
    output reg o_irq
);
// the instruction issues only on a cycle the cpu clock runs, so a
// stopped or dozing core cannot enter power save by accident
always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
        o_exec <= 1'b0;
        o_mode <= 1'b0;
        o_irq <= 1'b0;
    end else begin
        o_exec <= i_go && i_cpu_clk_en;
        o_mode <= i_mode;
        o_irq <= i_irq_req;
    end
end
endmodule

// ==== tb/cfps_ctrl_bench.sv ====
/* bench for cfps_ctrl: apb reads scored by a queue, a cpu model issues
   power save and interrupts. assumes the cfps_regs.vh map. */
`timescale 1ns/10ps
`include "cfps_regs.vh"
module cfps_ctrl_bench;
reg clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
reg go = 0, gmode = 0, irq_req = 0, wdt_to = 0, osc_fail = 0;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0;
reg [15:0] ep = 16'h1fab;
wire pready, pslverr, exec, mode, irq, cpu_en, wdt_clr, trap, osc_en;
wire pll, low_power_rc_osc, fail_safe_clock_monitor;
wire [31:0] prdata;
wire [2:0] sel;
wire [15:0] pce;
integer miscompares = 0, n_compared = 0, seed = 9, i, n;
logic [32:0] expq[$];
// 40 mhz system clock
always #12.5 clk = ~clk;
cfps_ctrl dut (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_power_save_instr_exec(exec), .i_power_save_instr_mode(mode),
    .i_irq_pending(irq), .i_wdt_timeout(wdt_to), .i_osc_fail(osc_fail),
    .o_cpu_clk_en(cpu_en), .o_wdt_clear(wdt_clr), .o_clk_fail_trap(trap),
    .o_sys_osc_en(osc_en), .o_sys_clk_sel(sel), .o_pll_en(pll),
    .o_low_power_rc_osc_en(low_power_rc_osc), .o_fail_safe_clock_monitor_active(fail_safe_clock_monitor),
    .o_periph_clk_en(pce));
cfps_cpu_model cpu (.i_sys_clk(clk), .i_rstn(rstn), .i_cpu_clk_en(cpu_en),
    .i_go(go), .i_mode(gmode), .i_irq_req(irq_req), .o_exec(exec),
    .o_mode(mode), .o_irq(irq));
////////////////////////////////////////
task automatic chk(input string nm, input logic [32:0] got, exp);
    n_compared++;
    if (got !== exp) begin
        miscompares++;
        $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
endtask
task automatic tick(input integer k);
    repeat (k) @(posedge clk);
    #1;
endtask
// one apb transfer; a read leaves its expected answer in the queue
task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    if (!wr) expq.push_back(e);
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    penable <= 0;
endtask
// enter sleep or idle, wake by late irq, watchdog or coincident irq
task automatic ps(input logic md, input integer src);
    logic [2:0] s0;
    s0 = sel;
    @(posedge clk);
    go <= 1;
    gmode <= md;
    irq_req <= (src == 0);
    @(posedge clk) go <= 0;
    tick(2);
    chk("entry", {wdt_clr, cpu_en, osc_en, low_power_rc_osc, fail_safe_clock_monitor, pce}, {2'b10, md,
        1'b1, md, md ? ep : ep & `CFPS_PER_EXTCLK});
    if (src == 1) @(posedge clk) irq_req <= 1;
    if (src == 2) @(posedge clk) wdt_to <= 1;
    n = 0;
    while (cpu_en !== 1'b1 && n < 30) begin
        tick(1);
        n++;
    end
    chk("wake", n, src == 1 ? 5 : 4);
    chk("source", {sel, osc_en, pce}, {s0, 1'b1, ep});
    @(posedge clk);
    irq_req <= 0;
    wdt_to <= 0;
    tick(4);
endtask
task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
////////////////////////////////////////
// answers return in request order, so the oldest note is the match
always @(posedge clk)
    if (pready === 1'b1 && pwrite === 1'b0)
        chk("read", {pslverr, prdata}, expq.pop_front());
// main sequence
initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    tick(1);
    chk("reset", {pce, cpu_en, osc_en, low_power_rc_osc, fail_safe_clock_monitor}, {16'h1fab, 4'hc});
    apb(0, `CFPS_OFS_CFG, 0, 33'h1);
    apb(0, `CFPS_OFS_CLOCK_DIVISOR_REG, 0, 33'h0);
    apb(0, 12'h010, 0, 33'h100000000);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
        n = $random(seed);
        apb(1, `CFPS_OFS_PMD, n, 0);
        // the gate moves one edge after the write lands, not yet here
        #1;
        chk("gate hold", pce, ep);
        ep = `CFPS_PER_PRESENT & ~n[15:0];
        tick(1);
        chk("gate", pce, ep);
    end
    apb(1, `CFPS_OFS_PMD, 0, 0);
    ep = 16'h1fab;
    $display("test gating done");
    for (i = 0; i < 8; i++) begin
        apb(1, `CFPS_OFS_CLOCK_DIVISOR_REG, 32'h800 | (i << 12), 0);
        tick(130);
        n = 0;
        repeat (256) begin
            @(posedge clk);
            n += cpu_en;
        end
        chk("doze", n, 256 >> i);
    end
    for (i = 0; i < 2; i++) begin
        apb(1, `CFPS_OFS_CLOCK_DIVISOR_REG, 32'h3800 | (i << 15), 0);
        @(posedge clk) irq_req <= 1;
        tick(4);
        apb(0, `CFPS_OFS_CLOCK_DIVISOR_REG, 0, i ? 33'hb000 : 33'h3800);
        @(posedge clk) irq_req <= 0;
    end
    apb(1, `CFPS_OFS_CLOCK_DIVISOR_REG, 0, 0);
    $display("test doze done");
    apb(1, `CFPS_OFS_CFG, 32'h56, 0);
    tick(2);
    chk("run", {sel, pll, low_power_rc_osc, fail_safe_clock_monitor}, {3'h5, 3'h7});
    ps(1, 1);
    ps(0, 2);
    ps(0, 0);
    ps(1, 0);
    $display("test power save done");
    @(posedge clk) osc_fail <= 1;
    @(posedge clk) osc_fail <= 0;
    #1 chk("trap", {trap, sel, pll}, {1'b1, 3'h0, 1'b1});
    // fail flag sticky, monitor active, fast rc still selected
    apb(0, `CFPS_OFS_STAT, 0, 33'h3);
    apb(1, `CFPS_OFS_CFG, 32'h57, 0);
    tick(2);
    @(posedge clk) osc_fail <= 1;
    @(posedge clk) osc_fail <= 0;
    #1 chk("no trap", {trap, fail_safe_clock_monitor, sel}, 0);
    $display("test fail done");
    wrap_up;
end
// a hang ends the run through the same closing task
initial begin
    #(25 * 40000);
    miscompares++;
    wrap_up;
end
endmodule
